// file: common/fts_sram_defs.vh
/*
 * Constants for the flow-through burst SRAM: array geometry, lane layout,
 * write-queue geometry, burst control state codes and strap reset value.
 * Assumes inclusion by the design file and the assertion file; it defines macros and nothing else.
 */
`ifndef FTS_SRAM_DEFS_VH
`define FTS_SRAM_DEFS_VH

// Array geometry
`define FTS_ADDR_W 18
`define FTS_WORDS 262144
`define FTS_DATA_W 16
`define FTS_PAR_W 2
`define FTS_WORD_W 18

// One lane is 8 data bits plus one parity bit
`define FTS_LANE_W 9
`define FTS_LANES 2

// Burst counter width (two low address bits)
`define FTS_BURST_W 2

// Write queue: address, lane mask and word per entry
`define FTS_Q_W 38
`define FTS_Q_DEPTH 8
`define FTS_Q_AW 3

// Burst control states
`define FTS_ST_DESEL 2'b00
`define FTS_ST_READ 2'b01
`define FTS_ST_WRITE 2'b10

// Order strap: high is interleaved; reset value stands for a floating strap
`define FTS_ORDER_INTERLEAVED 1'b1
`define FTS_STRAP_RST 1'b1

`endif

// file: logic/fts_sram.v
/*
 * Flow-through burst SRAM core, 256K words of 18 bits, with its write queue.
 * Assumes a controller on ref_clk driving all synchronous inputs, a static
 * order strap, and a bench that resolves the shared data wires from the enables.
 */
`timescale 1ns/1ps
`include "fts_sram_defs.vh"

module fts_fifo #(
    parameter W = `FTS_Q_W,
    parameter DEPTH = `FTS_Q_DEPTH,
    parameter AW = `FTS_Q_AW
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] wr_ptr_next;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW-1:0] rd_ptr_next;
    reg [AW:0] count_reg;
    reg [AW:0] count_next;
    wire push;
    wire pop;

    // Pointers wrap by their width, so DEPTH must be a power of two
    function [AW-1:0] ptr_inc;
        input [AW-1:0] ptr;
        begin
            ptr_inc = ptr + 1'b1;
        end
    endfunction

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Full and empty follow the count alone, no pointer compare
    always @* begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            wr_ptr_next = ptr_inc(wr_ptr_reg);
        end
        if (pop) begin
            rd_ptr_next = ptr_inc(rd_ptr_reg);
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule // fts_fifo

module fts_sram (
    input wire ref_clk,
    input wire sys_rst,
    input wire clock_qualify_n,
    input wire [`FTS_ADDR_W-1:0] address,
    input wire chip_select_a_n,
    input wire chip_select_hi,
    input wire chip_select_c_n,
    input wire write_enable_n,
    input wire [`FTS_LANES-1:0] byte_lane_select_n,
    input wire burst_step_or_load,
    input wire output_drive_n,
    input wire burst_order_strap,
    input wire [`FTS_DATA_W-1:0] dq_in,
    output wire [`FTS_DATA_W-1:0] dq_out,
    output wire dq_oe,
    input wire [`FTS_PAR_W-1:0] parity_in,
    output wire [`FTS_PAR_W-1:0] parity_out,
    output wire parity_oe
);
    // Word layout: {parity1, data15..8, parity0, data7..0}, lane i at bits 9i+8..9i
    function [`FTS_WORD_W-1:0] pack_word;
        input [`FTS_DATA_W-1:0] d;
        input [`FTS_PAR_W-1:0] p;
        begin
            pack_word = {p[1], d[15:8], p[0], d[7:0]};
        end
    endfunction

    function [`FTS_WORD_W-1:0] lane_merge;
        input [`FTS_WORD_W-1:0] old_w;
        input [`FTS_WORD_W-1:0] new_w;
        input [`FTS_LANES-1:0] wr_mask;
        begin
            lane_merge[8:0] = wr_mask[0] ? new_w[8:0] : old_w[8:0];
            lane_merge[17:9] = wr_mask[1] ? new_w[17:9] : old_w[17:9];
        end
    endfunction

    function [`FTS_BURST_W-1:0] burst_lo;
        input [`FTS_BURST_W-1:0] start;
        input [`FTS_BURST_W-1:0] step;
        input interleaved;
        begin
            if (interleaved == `FTS_ORDER_INTERLEAVED) begin
                burst_lo = start ^ step;
            end else begin
                burst_lo = start + step;
            end
        end
    endfunction

    function [`FTS_BURST_W-1:0] step_up;
        input [`FTS_BURST_W-1:0] step;
        begin
            step_up = step + 1'b1;
        end
    endfunction

    // Both pin groups share this gate so parity never parts from data
    function pin_drive;
        input read_cycle;
        input drive_n;
        begin
            pin_drive = read_cycle & ~drive_n;
        end
    endfunction

    // No reset on the array: contents are undefined at power up
    reg [`FTS_WORD_W-1:0] array_reg [0:`FTS_WORDS-1];

    reg strap_meta_reg;
    reg strap_reg;
    reg [1:0] st_reg;
    reg [1:0] st_next;
    reg [`FTS_ADDR_W-3:0] base_reg;
    reg [`FTS_ADDR_W-3:0] base_next;
    reg [`FTS_BURST_W-1:0] start_reg;
    reg [`FTS_BURST_W-1:0] start_next;
    reg [`FTS_BURST_W-1:0] step_reg;
    reg [`FTS_BURST_W-1:0] step_next;
    reg [`FTS_LANES-1:0] bw_n_reg;
    reg [`FTS_LANES-1:0] bw_n_next;
    reg wpend_reg;
    reg wpend_next;
    reg drive_reg;
    reg drive_next;

    wire q_in_ready;
    wire q_out_valid;
    wire [`FTS_Q_W-1:0] q_out_data;
    wire qualified;
    wire selected;
    wire [`FTS_ADDR_W-1:0] beat_addr;
    wire [`FTS_ADDR_W-1:0] head_addr;
    wire [`FTS_LANES-1:0] head_mask;
    wire [`FTS_WORD_W-1:0] head_word;
    wire [`FTS_WORD_W-1:0] core_word;
    reg [`FTS_WORD_W-1:0] read_word;
    wire fwd_hit;
    wire [`FTS_Q_W-1:0] q_in_data;
    wire push;
    wire drain;

    // A full write queue stalls the block like a masked clock
    assign qualified = ~clock_qualify_n & q_in_ready;
    assign selected = ~chip_select_a_n & chip_select_hi & ~chip_select_c_n;

    assign beat_addr = {base_reg, burst_lo(start_reg, step_reg, strap_reg)};

    // Strap is a static pin but still crosses into the clock domain
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_meta_reg <= `FTS_STRAP_RST;
            strap_reg <= `FTS_STRAP_RST;
        end else begin
            strap_meta_reg <= burst_order_strap;
            strap_reg <= strap_meta_reg;
        end
    end

    always @* begin
        st_next = st_reg;
        base_next = base_reg;
        start_next = start_reg;
        step_next = step_reg;
        bw_n_next = bw_n_reg;
        wpend_next = wpend_reg;
        drive_next = drive_reg;
        if (qualified) begin
            if (!burst_step_or_load) begin
                base_next = address[`FTS_ADDR_W-1:2];
                start_next = address[1:0];
                step_next = {`FTS_BURST_W{1'b0}};
                if (selected) begin
                    st_next = write_enable_n ? `FTS_ST_READ : `FTS_ST_WRITE;
                end else begin
                    st_next = `FTS_ST_DESEL;
                end
            end else begin
                // Advance ignores selects and write enable
                case (st_reg)
                    `FTS_ST_DESEL: begin
                        st_next = `FTS_ST_DESEL;
                    end
                    `FTS_ST_READ: begin
                        step_next = step_up(step_reg);
                    end
                    `FTS_ST_WRITE: begin
                        step_next = step_up(step_reg);
                    end
                    default: begin
                        st_next = `FTS_ST_DESEL;
                    end
                endcase
            end
            bw_n_next = byte_lane_select_n;
            wpend_next = (st_next == `FTS_ST_WRITE);
            // Limitation: a read loaded straight after a deselect drives at once
            drive_next = (st_next == `FTS_ST_READ);
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= `FTS_ST_DESEL;
            base_reg <= {(`FTS_ADDR_W-2){1'b0}};
            start_reg <= {`FTS_BURST_W{1'b0}};
            step_reg <= {`FTS_BURST_W{1'b0}};
            bw_n_reg <= {`FTS_LANES{1'b1}};
            wpend_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            base_reg <= base_next;
            start_reg <= start_next;
            step_reg <= step_next;
            bw_n_reg <= bw_n_next;
            wpend_reg <= wpend_next;
            drive_reg <= drive_next;
        end
    end

    // Write data is taken one qualified edge after its command
    assign push = qualified & wpend_reg;

    // Entry holds beat address, active-high lane mask and packed word
    assign q_in_data = {beat_addr, ~bw_n_reg, pack_word(dq_in, parity_in)};

    // Array updates only on edges with clock_qualify_n low, full queue or not, so a masked clock freezes it
    assign drain = q_out_valid & ~clock_qualify_n;

    fts_fifo #(
        .W(`FTS_Q_W),
        .DEPTH(`FTS_Q_DEPTH),
        .AW(`FTS_Q_AW)
    ) u_wq (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(push),
        .in_ready(q_in_ready),
        .in_data(q_in_data),
        .out_valid(q_out_valid),
        .out_ready(~clock_qualify_n),
        .out_data(q_out_data)
    );

    // Queue head split back into its three fields
    assign head_addr = q_out_data[`FTS_Q_W-1:`FTS_WORD_W+`FTS_LANES];
    assign head_mask = q_out_data[`FTS_WORD_W+`FTS_LANES-1:`FTS_WORD_W];
    assign head_word = q_out_data[`FTS_WORD_W-1:0];

    always @(posedge ref_clk) begin
        if (drain) begin
            array_reg[head_addr] <= lane_merge(array_reg[head_addr], head_word, head_mask);
        end
    end

    // Forward a queued write so a read right behind it sees the new bytes
    assign core_word = array_reg[beat_addr];
    assign fwd_hit = q_out_valid && (head_addr == beat_addr);
    always @* begin
        read_word = core_word;
        if (fwd_hit) begin
            read_word = lane_merge(core_word, head_word, head_mask);
        end
    end

    // Flow-through: no output stage, data follows the captured address
    // Trade-off: combinational read path, bought for zero read latency
    assign dq_out = {read_word[16:9], read_word[7:0]};
    assign parity_out = {read_word[17], read_word[8]};

    // Output enable is asynchronous through output_drive_n
    assign dq_oe = pin_drive(drive_reg, output_drive_n);
    assign parity_oe = pin_drive(drive_reg, output_drive_n);
endmodule // fts_sram

// file: testbench/fts_sram_sva.sv
/* Port assertions for the flow-through burst SRAM.
   Assumes a bind to fts_sram and the single ref_clk domain. */
`timescale 1ns/1ps
`include "fts_sram_defs.vh"
module fts_sram_sva (
    input logic ref_clk,
    input logic sys_rst,
    input logic clock_qualify_n,
    input logic [`FTS_ADDR_W-1:0] address,
    input logic chip_select_a_n,
    input logic chip_select_hi,
    input logic chip_select_c_n,
    input logic write_enable_n,
    input logic [`FTS_LANES-1:0] byte_lane_select_n,
    input logic burst_step_or_load,
    input logic output_drive_n,
    input logic burst_order_strap,
    input logic [`FTS_DATA_W-1:0] dq_in,
    input logic [`FTS_DATA_W-1:0] dq_out,
    input logic dq_oe,
    input logic [`FTS_PAR_W-1:0] parity_in,
    input logic [`FTS_PAR_W-1:0] parity_out,
    input logic parity_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire go = !clock_qualify_n;
    wire ld = go && !burst_step_or_load;
    wire sel = !chip_select_a_n && chip_select_hi && !chip_select_c_n;
    a_reset_quiet: assert property ($fell(sys_rst) |-> !dq_oe)
        else $error("outputs driven right after reset");
    a_desel_quiet: assert property (ld && !sel |=> !dq_oe)
        else $error("outputs driven after a deselect");
    a_write_quiet: assert property (ld && sel && !write_enable_n |=> !dq_oe)
        else $error("outputs driven in a write cycle");
    a_read_drive: assert property (ld && sel && write_enable_n ##1 !output_drive_n |-> dq_oe)
        else $error("read cycle not driving");
    a_drive_gate: assert property (output_drive_n |-> !dq_oe)
        else $error("outputs driven with output enable high");
    a_parity_twin: assert property (parity_oe == dq_oe)
        else $error("parity enable differs from data enable");
    a_freeze_hold: assert property (
        clock_qualify_n ##1 $stable(output_drive_n) |-> $stable(dq_oe))
        else $error("state moved on a masked edge");
    a_burst_keep: assert property (
        go && burst_step_or_load && dq_oe ##1 !output_drive_n |-> dq_oe)
        else $error("read burst dropped on advance");
    a_adv_idle: assert property (ld && !sel ##1 go && burst_step_or_load |=> !dq_oe)
        else $error("advance after deselect started an access");
endmodule // fts_sram_sva
bind fts_sram fts_sram_sva chk_i (.ref_clk, .sys_rst, .clock_qualify_n, .address,
    .chip_select_a_n, .chip_select_hi, .chip_select_c_n, .write_enable_n, .byte_lane_select_n,
    .burst_step_or_load, .output_drive_n, .burst_order_strap, .dq_in, .dq_out, .dq_oe,
    .parity_in, .parity_out, .parity_oe);

// file: testbench/fts_ctrl_model.sv
/* Controller side of the shared data and parity wires.
   Assumes the bench says when write data is to be driven. */
`timescale 1ns/1ps
module fts_ctrl_model (
    input logic ref_clk,
    input logic [15:0] dq_out,
    input logic dq_oe,
    input logic [1:0] parity_out,
    input logic parity_oe,
    input logic host_drive,
    input logic [17:0] host_data,
    output logic [15:0] dq_in,
    output logic [1:0] parity_in
);
    logic [17:0] float_val = 18'h0;
    logic [17:0] wire_val;
    // Write data sits on the wires for the edge after its command
    always_comb begin
        wire_val = float_val;
        if (host_drive)
            wire_val = host_data;
        if (dq_oe)
            wire_val[15:0] = host_drive ? 16'hxxxx : dq_out;
        if (parity_oe)
            wire_val[17:16] = host_drive ? 2'hx : parity_out;
    end
    // Released wires toggle so a stale value cannot pass as data
    always @(posedge ref_clk)
        float_val <= ~float_val;
    assign dq_in = wire_val[15:0];
    assign parity_in = wire_val[17:16];
endmodule // fts_ctrl_model

// file: testbench/fts_sram_test.sv
/* Self-checking bench for fts_sram with a controller model on the wires.
   Assumes fts_sram_sva is bound to the design. */
`timescale 1ns/1ps
module fts_sram_test;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clock_qualify_n = 1'b1;
    logic [17:0] address = 18'h0;
    logic [2:0] sel = 3'h0;
    logic write_enable_n = 1'b1;
    logic [1:0] byte_lane_select_n = 2'h3;
    logic burst_step_or_load = 1'b0;
    logic output_drive_n = 1'b0;
    logic burst_order_strap = 1'b1;
    logic order_next = 1'b1;
    logic host_drive = 1'b0;
    logic [17:0] host_data = 18'h0;
    logic [15:0] dq_in, dq_out;
    logic [1:0] parity_in, parity_out;
    logic dq_oe, parity_oe, wr_pend = 1'b0;
    logic [17:0] mem [bit [17:0]];
    logic [1:0] st = 2'h0, stp = 2'h0, wr_lanes = 2'h0;
    logic [17:0] base = 18'h0, cur = 18'h0, wr_addr = 18'h0;
    int mismatches = 0, cmp_count = 0;
    initial forever #25 ref_clk = ~ref_clk;
    fts_sram dut (.ref_clk, .sys_rst, .clock_qualify_n, .address, .chip_select_a_n(sel[2]),
        .chip_select_hi(sel[1]), .chip_select_c_n(sel[0]), .write_enable_n, .byte_lane_select_n,
        .burst_step_or_load, .output_drive_n, .burst_order_strap, .dq_in, .dq_out, .dq_oe,
        .parity_in, .parity_out, .parity_oe);
    fts_ctrl_model ctrl (.ref_clk, .dq_out, .dq_oe, .parity_out, .parity_oe, .host_drive,
        .host_data, .dq_in, .parity_in);
    function automatic logic [17:0] ref_get(input logic [17:0] a);
        return mem.exists(a) ? mem[a] : 18'hxxxxx;
    endfunction
    function automatic logic [1:0] low_bits(input logic [1:0] s, input logic [1:0] k,
                                            input logic il);
        return il ? (s ^ k) : (s + k);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp || $isunknown(exp)) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One qualified beat; the previous write beat's data rides on this edge
    task automatic beat(input logic ld, input logic [2:0] s, input logic we,
                        input logic [17:0] a, input logic [1:0] ln);
        logic [17:0] w;
        @(negedge ref_clk);
        burst_order_strap = order_next;
        host_drive = wr_pend;
        host_data = 18'($urandom);
        w = ref_get(wr_addr);
        if (!wr_lanes[0])
            {w[16], w[7:0]} = {host_data[16], host_data[7:0]};
        if (!wr_lanes[1])
            {w[17], w[15:8]} = {host_data[17], host_data[15:8]};
        if (wr_pend)
            mem[wr_addr] = w;
        {burst_step_or_load, sel, write_enable_n, address, byte_lane_select_n} = {ld, s, we, a, ln};
        clock_qualify_n = 1'b0;
        output_drive_n = ($urandom % 4) == 0;
        if (!ld) begin
            st = (s == 3'h2) ? (we ? 2'h1 : 2'h2) : 2'h0;
            base = a;
            stp = 2'h0;
        end else if (st != 2'h0) begin
            stp = stp + 2'h1;
        end
        cur = {base[17:2], low_bits(base[1:0], stp, burst_order_strap)};
        wr_pend = (st == 2'h2);
        wr_addr = cur;
        wr_lanes = ln;
        @(posedge ref_clk);
        host_drive <= 1'b0;
        #5;
        chk({parity_oe, dq_oe}, {2{(st == 2'h1) && !output_drive_n}});
        if (st == 2'h1 && !output_drive_n)
            chk({parity_out, dq_out}, ref_get(cur));
    endtask
    // Masked edge with selects, address, write enable and burst_step_or_load scrambled
    task automatic hold();
        @(negedge ref_clk);
        clock_qualify_n = 1'b1;
        {sel, address, write_enable_n, burst_step_or_load} = 23'($urandom);
        @(posedge ref_clk);
        #5;
        chk(dq_oe, (st == 2'h1) && !output_drive_n);
        if (st == 2'h1 && !output_drive_n)
            chk({parity_out, dq_out}, ref_get(cur));
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        logic [17:0] a;
        void'($urandom(32'ha3b0));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        // Fill both groups whole so later reads never expect unknowns
        for (int g = 0; g < 2; g++) begin
            beat(1'b0, 3'h2, 1'b0, g ? 18'h3fffc : 18'h0, 2'h0);
            repeat (3) beat(1'b1, 3'h2, 1'b0, 18'h0, 2'h0);
        end
        for (int i = 0; i < 8; i++)
            beat(1'b0, 3'(i), 1'b1, 18'h0, 2'h0);
        beat(1'b0, 3'h0, 1'b1, 18'h0, 2'h0);
        beat(1'b1, 3'h2, 1'b1, 18'h0, 2'h0);
        for (int m = 0; m < 2; m++) begin
            order_next = !m[0];
            repeat (3) beat(1'b0, 3'h0, 1'b1, 18'h0, 2'h0);
            repeat (6) begin
                a = ($urandom % 2) ? 18'h3fffc : 18'h0;
                a[1:0] = 2'($urandom);
                beat(1'b0, 3'h2, 1'b0, a, 2'($urandom));
                repeat (3) beat(1'b1, 3'($urandom), 1'($urandom), 18'($urandom), 2'($urandom));
                beat(1'b0, 3'h2, 1'b1, a, 2'h3);
                hold();
                repeat (4) beat(1'b1, 3'($urandom), 1'($urandom), 18'($urandom), 2'h3);
            end
        end
        wrap_up();
    end
    // About thirteen times the expected run length
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
endmodule // fts_sram_test
